// file: common/dac_load_defs.svh
`ifndef DAC_LOAD_DEFS_SVH
`define DAC_LOAD_DEFS_SVH

// frame layout: leading pad bits, then the code msb first
`define DAC_FRAME_BITS 5'h18
`define DAC_PAD_BITS 5'h06
`define DAC_DATA_BITS 18
`define DAC_CNT_BITS 5
`define DAC_CNT_MAX 5'h1f

// codes loaded by the clear input
`define DAC_ZERO_CODE 18'h00000
`define DAC_MIDSCALE_CODE 18'h20000

// fastest accepted serial clock
`define DAC_SCLK_MAX_MHZ 50
`define DAC_SCLK_MIN_PERIOD_NS (1000 / `DAC_SCLK_MAX_MHZ)

// system clock and the chip-select high time needed for the crossing
`define DAC_SYS_CLK_MHZ 20
`define DAC_CS_HIGH_MIN_CYCLES 3

// pin synchroniser lanes
`define DAC_SYNC_LANES 4
`define DAC_LANE_CS 0
`define DAC_LANE_STROBE 1
`define DAC_LANE_CLEAR 2
`define DAC_LANE_SLEEP 3

`endif

// file: common/dac_load_pkg.sv
package dac_load_pkg;

  typedef enum logic [2:0] {
    MODE_CLEAR = 3'h1,
    MODE_RUN = 3'h2,
    MODE_SLEEP = 3'h4
  } out_mode_t;

endpackage

// file: design/serial_shift_capture.sv
`timescale 1ns/1ps
`include "dac_load_defs.svh"

module serial_shift_capture (
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  output logic [`DAC_DATA_BITS-1:0] o_shift,
  output logic o_complete,
  output logic o_overlong
);

  logic [`DAC_DATA_BITS-1:0] shift_r;
  logic [`DAC_CNT_BITS-1:0] count_r;
  logic fresh_r;

  // sample on rising sclk only while selected; msb first, last 18 bits kept
  always_ff @(posedge i_sclk) begin
    if (!i_cs_n) begin
      shift_r <= {shift_r[`DAC_DATA_BITS-2:0], i_sdi};
    end
  end

  // marks the first sclk of a frame; preset while deselected
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  // length must survive the chip-select rise until the system side reads it,
  // so it restarts on the first sclk of the next frame instead of on deselect;
  // limitation: a frame with no sclk at all reports the previous length
  always_ff @(posedge i_sclk) begin
    if (!i_cs_n) begin
      if (fresh_r) begin
        count_r <= 5'h01;
      end else if (count_r != `DAC_CNT_MAX) begin
        count_r <= count_r + 5'h01;
      end
    end
  end

  assign o_shift = shift_r;
  assign o_complete = (count_r >= `DAC_FRAME_BITS);
  assign o_overlong = (count_r > `DAC_FRAME_BITS);

endmodule

// file: design/serial_dac_load_interface.sv
`timescale 1ns/1ps
`include "dac_load_defs.svh"
// Function
// - chip select rise copies shift into input
// - strobe low: chip select rise updates output
// - 24-bit frame, 6 pad, 18 data bits
// - host drives on fall, device samples rise
// - serial clock up to 50 MHz
// - overlong frame keeps last 18 bits
// - active-low strobe updates output from input
// - clear with select low loads zero
// - clear with select high loads midscale
// - sleep request powers down, grounds output
// - serial clock idles low, mode zero

module serial_dac_load_interface (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  input wire logic i_output_update_strobe_n,
  input wire logic i_clear_n,
  input wire logic i_reset_level_select,
  input wire logic i_sleep_request,
  output logic [`DAC_DATA_BITS-1:0] o_input_code,
  output logic [`DAC_DATA_BITS-1:0] o_output_code,
  output logic o_output_updated,
  output logic o_frame_short,
  output logic o_frame_overlong,
  output logic o_sleeping,
  output logic o_output_ground
);

  logic [`DAC_DATA_BITS-1:0] link_shift;
  logic link_complete;
  logic link_overlong;

  // link side; values stay frozen once chip select is high and sclk idles
  serial_shift_capture u_capture (
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .i_sdi(i_sdi),
    .o_shift(link_shift),
    .o_complete(link_complete),
    .o_overlong(link_overlong)
  );

  logic [`DAC_SYNC_LANES-1:0] pins;
  logic [`DAC_SYNC_LANES-1:0] meta_r;
  logic [`DAC_SYNC_LANES-1:0] sync_r;
  logic [`DAC_SYNC_LANES-1:0] prev_r;

  assign pins[`DAC_LANE_CS] = i_cs_n;
  assign pins[`DAC_LANE_STROBE] = i_output_update_strobe_n;
  assign pins[`DAC_LANE_CLEAR] = i_clear_n;
  assign pins[`DAC_LANE_SLEEP] = i_sleep_request;

  // two-flop synchronisers; all idle levels reset high except sleep
  genvar g;
  generate
    for (g = 0; g < `DAC_SYNC_LANES; g = g + 1) begin : g_sync
      localparam logic IDLE = (g == `DAC_LANE_SLEEP) ? 1'b0 : 1'b1;
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          meta_r[g] <= IDLE;
          sync_r[g] <= IDLE;
          prev_r[g] <= IDLE;
        end else begin
          meta_r[g] <= pins[g];
          sync_r[g] <= meta_r[g];
          prev_r[g] <= sync_r[g];
        end
      end
    end
  endgenerate

  // the select level is a strap; sample it through two flops as well
  logic sel_meta_r;
  logic sel_sync_r;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_meta_r <= 1'b0;
      sel_sync_r <= 1'b0;
    end else begin
      sel_meta_r <= i_reset_level_select;
      sel_sync_r <= sel_meta_r;
    end
  end

  logic cs_rise;
  logic strobe_low;
  logic clear_active;
  logic sleep_active;

  // frame data is only read after the synced edge: by then sclk has stopped,
  // which is why chip select must stay high a few system clocks
  assign cs_rise = sync_r[`DAC_LANE_CS] & ~prev_r[`DAC_LANE_CS];
  assign strobe_low = ~sync_r[`DAC_LANE_STROBE];
  assign clear_active = ~sync_r[`DAC_LANE_CLEAR];
  assign sleep_active = sync_r[`DAC_LANE_SLEEP];

  dac_load_pkg::out_mode_t mode_r;
  dac_load_pkg::out_mode_t mode_nxt;

  always_comb begin
    case (mode_r)
      dac_load_pkg::MODE_CLEAR: begin
        if (clear_active) begin
          mode_nxt = dac_load_pkg::MODE_CLEAR;
        end else if (sleep_active) begin
          mode_nxt = dac_load_pkg::MODE_SLEEP;
        end else begin
          mode_nxt = dac_load_pkg::MODE_RUN;
        end
      end
      dac_load_pkg::MODE_RUN: begin
        if (clear_active) begin
          mode_nxt = dac_load_pkg::MODE_CLEAR;
        end else if (sleep_active) begin
          mode_nxt = dac_load_pkg::MODE_SLEEP;
        end else begin
          mode_nxt = dac_load_pkg::MODE_RUN;
        end
      end
      dac_load_pkg::MODE_SLEEP: begin
        if (clear_active) begin
          mode_nxt = dac_load_pkg::MODE_CLEAR;
        end else if (sleep_active) begin
          mode_nxt = dac_load_pkg::MODE_SLEEP;
        end else begin
          mode_nxt = dac_load_pkg::MODE_RUN;
        end
      end
      default: begin
        mode_nxt = dac_load_pkg::MODE_CLEAR;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_r <= dac_load_pkg::MODE_CLEAR;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  logic [`DAC_DATA_BITS-1:0] input_r;
  logic [`DAC_DATA_BITS-1:0] latch_r;
  logic [`DAC_DATA_BITS-1:0] latch_nxt;
  logic updated_r;
  logic load_latch;

  // input register only changes on the end of a frame
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      input_r <= `DAC_ZERO_CODE;
    end else if (cs_rise) begin
      input_r <= link_shift;
    end
  end

  // strobe low makes the latch follow; at a frame end it takes the new word
  always_comb begin
    load_latch = 1'b0;
    latch_nxt = latch_r;
    if (clear_active) begin
      load_latch = 1'b1;
      latch_nxt = sel_sync_r ? `DAC_MIDSCALE_CODE : `DAC_ZERO_CODE;
    end else if (strobe_low && cs_rise) begin
      load_latch = 1'b1;
      latch_nxt = link_shift;
    end else if (strobe_low) begin
      load_latch = 1'b1;
      latch_nxt = input_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      latch_r <= `DAC_ZERO_CODE;
    end else if (load_latch) begin
      latch_r <= latch_nxt;
    end
  end

  // pulse only when the driven code actually moves
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      updated_r <= 1'b0;
    end else begin
      updated_r <= load_latch && (latch_nxt != latch_r);
    end
  end

  logic short_r;
  logic overlong_r;

  // frame length status, held until the next frame ends
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      short_r <= 1'b0;
      overlong_r <= 1'b0;
    end else if (cs_rise) begin
      short_r <= ~link_complete;
      overlong_r <= link_overlong;
    end
  end

  logic sleep_r;
  logic ground_r;

  // sleep keeps the latch contents; only the output stage is parked
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sleep_r <= 1'b0;
      ground_r <= 1'b0;
    end else begin
      sleep_r <= (mode_nxt == dac_load_pkg::MODE_SLEEP);
      ground_r <= (mode_nxt == dac_load_pkg::MODE_SLEEP);
    end
  end

  assign o_input_code = input_r;
  assign o_output_code = latch_r;
  assign o_output_updated = updated_r;
  assign o_frame_short = short_r;
  assign o_frame_overlong = overlong_r;
  assign o_sleeping = sleep_r;
  assign o_output_ground = ground_r;

endmodule

// file: verification/dac_load_props.sv
`timescale 1ns/1ps
`include "dac_load_defs.svh"
module dac_load_props (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_cs_n,
  input wire logic i_output_update_strobe_n,
  input wire logic i_clear_n,
  input wire logic i_reset_level_select,
  input wire logic i_sleep_request,
  input wire logic [`DAC_DATA_BITS-1:0] o_input_code,
  input wire logic [`DAC_DATA_BITS-1:0] o_output_code,
  input wire logic o_output_updated,
  input wire logic o_sleeping,
  input wire logic o_output_ground
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // repetition counts cover the two synchroniser flops plus the register
  chk_clear_zero: assert property (
    (!i_clear_n && !i_reset_level_select)[*3] |=> o_output_code == `DAC_ZERO_CODE)
    else $error("clear did not load zero");
  chk_clear_mid: assert property (
    (!i_clear_n && i_reset_level_select)[*3] |=> o_output_code == `DAC_MIDSCALE_CODE)
    else $error("clear did not load midscale");
  chk_sleep_enter: assert property (
    (i_sleep_request && i_clear_n)[*3] |=> o_sleeping && o_output_ground)
    else $error("sleep not entered");
  chk_sleep_leave: assert property ((!i_sleep_request)[*3] |=> !o_sleeping)
    else $error("sleep not left");
  chk_strobe_follow: assert property (
    (!i_output_update_strobe_n && i_clear_n)[*4] |=> o_output_code == o_input_code)
    else $error("latch not following input register");
  chk_latch_hold: assert property (
    (i_output_update_strobe_n && i_clear_n)[*4] |=> $stable(o_output_code))
    else $error("latch moved without strobe");
  chk_input_freeze: assert property (i_cs_n[*5] |=> $stable(o_input_code))
    else $error("input register moved while deselected");
  // the pulse rises on the same edge as the latch, so compare one cycle back
  chk_update_pulse: assert property (
    o_output_updated |-> o_output_code != $past(o_output_code))
    else $error("update pulse without change");
endmodule
bind serial_dac_load_interface dac_load_props i_props (
  .i_clk(i_clk),
  .i_reset_n(i_reset_n),
  .i_cs_n(i_cs_n),
  .i_output_update_strobe_n(i_output_update_strobe_n),
  .i_clear_n(i_clear_n),
  .i_reset_level_select(i_reset_level_select),
  .i_sleep_request(i_sleep_request),
  .o_input_code(o_input_code),
  .o_output_code(o_output_code),
  .o_output_updated(o_output_updated),
  .o_sleeping(o_sleeping),
  .o_output_ground(o_output_ground)
);

// file: verification/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end
  // 48 ns period keeps under the fastest allowed serial clock
  task automatic send(input logic [31:0] bits, input int n);
    #7 o_cs_n = 1'b0;
    for (int k = n - 1; k >= 0; k--) begin
      o_sdi = bits[k];
      #24 o_sclk = 1'b1;
      #24 o_sclk = 1'b0;
    end
    #24 o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
  endtask
  // traffic meant for other devices on a shared bus, this one deselected
  task automatic stray(input int n);
    for (int k = 0; k < n; k++) begin
      o_sdi = k[0];
      #24 o_sclk = 1'b1;
      #24 o_sclk = 1'b0;
    end
  endtask
endmodule

// file: verification/test_serial_dac_load_interface.sv
`timescale 1ns/1ps
`include "dac_load_defs.svh"
module test_serial_dac_load_interface;
  logic i_clk, i_reset_n, i_sclk, i_cs_n, i_sdi, i_output_update_strobe_n;
  logic i_clear_n, i_reset_level_select, i_sleep_request;
  logic [`DAC_DATA_BITS-1:0] o_input_code, o_output_code;
  logic o_output_updated, o_frame_short, o_frame_overlong, o_sleeping, o_output_ground;
  int bad_count = 0;
  int total_checks = 0;
  serial_dac_load_interface i_dut (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .i_sdi(i_sdi),
    .i_output_update_strobe_n(i_output_update_strobe_n),
    .i_clear_n(i_clear_n),
    .i_reset_level_select(i_reset_level_select),
    .i_sleep_request(i_sleep_request),
    .o_input_code(o_input_code),
    .o_output_code(o_output_code),
    .o_output_updated(o_output_updated),
    .o_frame_short(o_frame_short),
    .o_frame_overlong(o_frame_overlong),
    .o_sleeping(o_sleeping),
    .o_output_ground(o_output_ground)
  );
  spi_host_model i_host (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_sdi(i_sdi));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // six cycles after the frame covers the crossing and the gap before the next
  task automatic frame(input logic [31:0] bits, input int n);
    @(negedge i_clk);
    i_host.send(bits, n);
    repeat (6) @(negedge i_clk);
  endtask
  task automatic t_held();
    frame(32'h00ab3c5a, 24);
    check(o_input_code, 18'h33c5a);
    check(o_output_code, 18'h00000);
    check({o_frame_short, o_frame_overlong}, 2'b00);
    i_output_update_strobe_n = 1'b0;
    repeat (3) @(negedge i_clk);
    check(o_output_code, 18'h33c5a);
    check(o_output_updated, 1'b1);
    @(negedge i_clk);
    check(o_output_updated, 1'b0);
  endtask
  task automatic t_direct();
    frame(32'h00c00001, 24);
    check(o_output_code, 18'h00001);
    frame(32'h0fc15a5a, 28);
    check(o_input_code, 18'h15a5a);
    check({o_frame_short, o_frame_overlong}, 2'b01);
    frame(32'h000fabcd, 20);
    check(o_input_code, 18'h3abcd);
    check({o_frame_short, o_frame_overlong}, 2'b10);
  endtask
  // stray clocks while deselected must not reach the shift register
  task automatic t_freeze();
    i_host.stray(8);
    check(o_input_code, 18'h3abcd);
    frame(32'h00000003, 2);
    check(o_input_code, 18'h2af37);
  endtask
  task automatic t_clear();
    i_output_update_strobe_n = 1'b1;
    for (int s = 0; s < 2; s++) begin
      i_reset_level_select = s[0];
      i_clear_n = 1'b0;
      repeat (5) @(negedge i_clk);
      check(o_output_code, s ? `DAC_MIDSCALE_CODE : `DAC_ZERO_CODE);
      i_clear_n = 1'b1;
      repeat (4) @(negedge i_clk);
    end
  endtask
  task automatic t_sleep();
    i_sleep_request = 1'b1;
    repeat (5) @(negedge i_clk);
    check({o_sleeping, o_output_ground}, 2'b11);
    check(o_output_code, `DAC_MIDSCALE_CODE);
    i_clear_n = 1'b0;
    repeat (5) @(negedge i_clk);
    check({o_sleeping, o_output_ground}, 2'b00);
    i_clear_n = 1'b1;
    repeat (5) @(negedge i_clk);
    check({o_sleeping, o_output_ground}, 2'b11);
    i_sleep_request = 1'b0;
    repeat (5) @(negedge i_clk);
    check({o_sleeping, o_output_ground}, 2'b00);
  endtask
  initial begin
    i_reset_n = 1'b0;
    i_output_update_strobe_n = 1'b1;
    i_clear_n = 1'b1;
    i_reset_level_select = 1'b0;
    i_sleep_request = 1'b0;
    repeat (4) @(negedge i_clk);
    i_reset_n = 1'b1;
    repeat (3) @(negedge i_clk);
    t_held();
    t_direct();
    t_freeze();
    t_clear();
    t_sleep();
    summarize();
  end
  // all frames and waits together stay well under this span
  initial begin
    #100000;
    bad_count++;
    summarize();
  end
endmodule
